// ==== rtl/bcd_commutation_decoder.sv ====
// Hall-to-drive commutation decoder with tach pulse and blanking
`timescale 1ns/10ps
`include "bcd_params.svh"
module bcd_commutation_decoder import bcd_pkg::*; #(
	parameter int TACH_CYCLES = `BCD_TACH_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sync_reset,
	input wire logic hall_pos_1,
	input wire logic hall_pos_2,
	input wire logic hall_pos_3,
	input wire logic direction,
	output logic [2:0] low_side,
	output logic [2:0] high_side_n,
	output logic tach_out,
	output logic [2:0] position
);
	logic [2:0] hall_now;
	logic hall_change;
	logic load;
	logic tach_pulse;
	logic [2:0] next_low;
	logic [2:0] next_high_n;
	bcd_state_t state;

	initial begin
		if (TACH_CYCLES < 1) begin
			$error("bcd_commutation_decoder: TACH_CYCLES must be at least 1");
		end
	end

	// Hall inputs are presumed 120-degree coded; others fall to off
	assign hall_now = {hall_pos_1, hall_pos_2, hall_pos_3};
	assign hall_change = (hall_now != position);
	// Latch is frozen while the tach output is high, its last cycle included
	assign load = hall_change && !tach_pulse && !tach_out && !sync_reset;

	// Latch the code on any change outside blanking
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			position <= `BCD_POS_RESET;
		end else if (sync_reset) begin
			position <= `BCD_POS_RESET;
		end else if (load) begin
			position <= hall_now;
		end
	end

	bcd_tach_pulse #(
		.WIDTH(TACH_CYCLES)
	) u_tach (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.trigger(load),
		.pulse(tach_pulse)
	);

	// Tach pulse starts with the load and marks the blanking window
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tach_out <= 1'b0;
		end else begin
			tach_out <= load || tach_pulse;
		end
	end

	// Tracks blanking for observability; blanking lasts the tach width
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= BCD_ARMED;
		end else begin
			case (state)
				BCD_ARMED: begin
					if (load) begin
						state <= BCD_BLANK;
					end
				end
				BCD_BLANK: begin
					if (!tach_pulse) begin
						state <= BCD_ARMED;
					end
				end
				default: begin
					state <= BCD_ARMED;
				end
			endcase
		end
	end

	// Decode of the latched code; one low-side and one high-side active for codes 1 to 6, none for 0 and 7
	always_comb begin
		next_low = `BCD_LS_OFF;
		next_high_n = `BCD_HS_OFF_N;
		if (direction) begin
			case (position)
				3'h1: begin next_low = 3'h2; next_high_n = 3'h6; end
				3'h3: begin next_low = 3'h4; next_high_n = 3'h6; end
				3'h2: begin next_low = 3'h4; next_high_n = 3'h5; end
				3'h6: begin next_low = 3'h1; next_high_n = 3'h5; end
				3'h4: begin next_low = 3'h1; next_high_n = 3'h3; end
				3'h5: begin next_low = 3'h2; next_high_n = 3'h3; end
				default: begin next_low = `BCD_LS_OFF; next_high_n = `BCD_HS_OFF_N; end
			endcase
		end else begin
			case (position)
				3'h5: begin next_low = 3'h4; next_high_n = 3'h5; end
				3'h4: begin next_low = 3'h4; next_high_n = 3'h6; end
				3'h6: begin next_low = 3'h2; next_high_n = 3'h6; end
				3'h2: begin next_low = 3'h2; next_high_n = 3'h3; end
				3'h3: begin next_low = 3'h1; next_high_n = 3'h3; end
				3'h1: begin next_low = 3'h1; next_high_n = 3'h5; end
				default: begin next_low = `BCD_LS_OFF; next_high_n = `BCD_HS_OFF_N; end
			endcase
		end
	end

	// Registered drives, forced off in reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			low_side <= `BCD_LS_OFF;
			high_side_n <= `BCD_HS_OFF_N;
		end else if (sync_reset) begin
			low_side <= `BCD_LS_OFF;
			high_side_n <= `BCD_HS_OFF_N;
		end else begin
			low_side <= next_low;
			high_side_n <= next_high_n;
		end
	end
endmodule

// ==== rtl/bcd_tach_pulse.sv ====
// Fixed-width tachometer pulse generator
`timescale 1ns/10ps
module bcd_tach_pulse #(
	parameter int WIDTH = 14000
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic trigger,
	output logic pulse
);
	localparam int CW = $clog2(WIDTH + 1);
	logic [CW-1:0] count;

	initial begin
		if (WIDTH < 1) begin
			$error("bcd_tach_pulse: WIDTH must be at least 1");
		end
	end

	// Retrigger is ignored while running so the width stays fixed
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else if (trigger && count == '0) begin
			count <= CW'(WIDTH);
		end else if (count != '0) begin
			count <= count - CW'(1);
		end
	end

	assign pulse = (count != '0);
endmodule

// ==== shared/bcd_params.svh ====
// Constants for the commutation decoder
// Notes on behaviour
// - Valid code drives exactly one low-side high and one high-side low.
// - Direction 1 table: 001 L2H1, 011 L3H1, 010 L3H2, 110 L1H2, 100 L1H3, 101 L2H3.
// - Direction 0 table: 101 L3H2, 100 L3H1, 110 L2H1, 010 L2H3, 011 L1H3, 001 L1H2.
// - All-low or all-high code turns every drive off regardless of direction.
// - Commutation is followed by blanking as long as the tach pulse.
// - A Hall change outside blanking and sync reset loads the position latch and starts the tach pulse.
// - Position latch load is inhibited while the tach pulse is high.
`ifndef BCD_PARAMS_SVH
`define BCD_PARAMS_SVH
`define BCD_CLK_PERIOD_NS 10
`define BCD_TACH_WIDTH_US 140
`define BCD_TACH_CYCLES ((`BCD_TACH_WIDTH_US * 1000) / `BCD_CLK_PERIOD_NS)
`define BCD_LS_OFF 3'h0
`define BCD_HS_OFF_N 3'h7
`define BCD_POS_RESET 3'h0
`endif

// ==== shared/bcd_pkg.sv ====
// Types for the commutation decoder
package bcd_pkg;
	typedef enum logic [1:0] {
		BCD_ARMED = 2'h1,
		BCD_BLANK = 2'h2
	} bcd_state_t;
endpackage

// ==== tb/bcd_commutation_checker.sv ====
// Port checker for the commutation decoder
`timescale 1ns/10ps
module bcd_checker #(
	parameter int TACH_CYCLES = 8
) (
	input wire logic sys_clk,
	reset_n,
	sync_reset,
	hall_pos_1,
	hall_pos_2,
	hall_pos_3,
	direction,
	tach_out,
	input wire logic [2:0] low_side,
	high_side_n,
	position
);
	logic [31:0] hi_cnt;
	wire logic [2:0] code = {hall_pos_1, hall_pos_2, hall_pos_3};
	wire logic good = position != 3'h0 && position != 3'h7;
	always_ff @(posedge sys_clk or negedge reset_n)
		if (!reset_n)
			hi_cnt <= 32'h0;
		else
			hi_cnt <= tach_out ? hi_cnt + 32'h1 : 32'h0;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_idle_diff;
		code != position && !tach_out && !sync_reset;
	endsequence
	a_load_take: assert property (s_idle_diff |=> position == $past(code))
		else $error("load missed");
	a_tach_start: assert property ($changed(position) && !$past(sync_reset) |-> tach_out)
		else $error("no tach pulse");
	a_tach_width: assert property ($fell(tach_out) |-> hi_cnt == TACH_CYCLES + 1)
		else $error("tach width");
	a_blank_hold: assert property (hi_cnt inside {[1:TACH_CYCLES]} |-> $stable(position))
		else $error("load in blanking");
	a_one_each: assert property (good && $stable(position) |-> $onehot(low_side) && $onehot(~high_side_n))
		else $error("not one drive each");
	a_no_clash: assert property ((low_side & ~high_side_n) == 3'h0)
		else $error("phase clash");
	a_illegal_off: assert property (!good && $stable(position) |-> low_side == 3'h0 && high_side_n == 3'h7)
		else $error("illegal not off");
	a_sync_off: assert property (sync_reset |=> position == 3'h0 && low_side == 3'h0 && high_side_n == 3'h7)
		else $error("sync not off");
	a_dir_swap: assert property ($changed(direction) && $stable(position) && good |=> low_side == ~$past(high_side_n))
		else $error("reverse wrong");
endmodule
bind bcd_commutation_decoder bcd_checker #(.TACH_CYCLES(TACH_CYCLES)) u_chk (.*);

// ==== tb/bcd_commutation_decoder_bench.sv ====
// Self-checking bench for the commutation decoder
`timescale 1ns/10ps
module bcd_commutation_decoder_bench;
	localparam logic [5:0] TBL [8] = '{6'h00, 6'h11, 6'h22, 6'h21, 6'h0C, 6'h14, 6'h0A, 6'h00};
	logic sys_clk = 1'b0;
	logic reset_n = 1'b1;
	logic sync_reset = 1'b0;
	logic direction = 1'b1;
	logic [2:0] code = 3'h0;
	logic h1, h2, h3, tach_out;
	logic [2:0] low_side, high_side_n, position;
	int num_errors = 0;
	int total_checks = 0;
	always #5 sys_clk = ~sys_clk;
	bcd_hall_src i_src (.code(code), .hall_pos_1(h1), .hall_pos_2(h2), .hall_pos_3(h3));
	bcd_commutation_decoder #(.TACH_CYCLES(8)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.sync_reset(sync_reset), .hall_pos_1(h1), .hall_pos_2(h2), .hall_pos_3(h3),
		.direction(direction), .low_side(low_side), .high_side_n(high_side_n),
		.tach_out(tach_out), .position(position));
	task automatic check(input logic [5:0] seen, input logic [5:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Reverse rotation is the forward table with the two sides swapped
	function automatic logic [5:0] want(input logic d, input logic [2:0] c);
		logic [5:0] t;
		t = d ? TBL[c] : {TBL[c][2:0], TBL[c][5:3]};
		return {t[5:3], ~t[2:0]};
	endfunction
	task automatic settle;
		int n;
		for (n = 0; n < 30; n++) begin
			@(negedge sys_clk);
			if (tach_out === 1'b0 && position === code) break;
		end
		if (n == 30) begin
			num_errors++;
			print_verdict();
		end
	endtask
	task automatic t_table;
		for (int d = 0; d < 2; d++) begin
			for (int c = 0; c < 8; c++) begin
				@(posedge sys_clk);
				direction <= d[0];
				code <= c[2:0];
				settle();
				check({low_side, high_side_n}, want(d[0], c[2:0]));
			end
		end
	endtask
	task automatic t_dir;
		@(posedge sys_clk) code <= 3'h3;
		settle();
		@(posedge sys_clk) direction <= ~direction;
		repeat (2) @(negedge sys_clk);
		check({low_side, high_side_n}, want(direction, 3'h3));
	endtask
	task automatic t_blank;
		@(posedge sys_clk) code <= 3'h1;
		@(posedge sys_clk) code <= 3'h3;
		repeat (4) @(negedge sys_clk);
		check({3'h0, position}, 6'h01);
		settle();
		check({low_side, high_side_n}, want(direction, 3'h3));
	endtask
	task automatic t_sync;
		@(posedge sys_clk) sync_reset <= 1'b1;
		repeat (2) @(negedge sys_clk);
		check({low_side, high_side_n}, 6'h07);
		@(posedge sys_clk) sync_reset <= 1'b0;
		settle();
		check({low_side, high_side_n}, want(direction, 3'h3));
	endtask
	task automatic t_areset;
		@(posedge sys_clk) reset_n <= 1'b0;
		@(negedge sys_clk);
		check({low_side, high_side_n}, 6'h07);
		check({tach_out, 2'h0, position}, 6'h00);
		@(posedge sys_clk) reset_n <= 1'b1;
		settle();
		check({low_side, high_side_n}, want(direction, 3'h3));
	endtask
	initial begin
		// A real falling edge so the asynchronous reset branches run
		reset_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_table();
		t_dir();
		t_blank();
		t_sync();
		t_areset();
		print_verdict();
	end
endmodule

// ==== tb/bcd_hall_src.sv ====
// Hall sensor source model
`timescale 1ns/10ps
module bcd_hall_src (
	input wire logic [2:0] code,
	output logic hall_pos_1,
	output logic hall_pos_2,
	output logic hall_pos_3
);
	assign {hall_pos_1, hall_pos_2, hall_pos_3} = code;
endmodule
